// ---- core/serial_port_pkg.sv ----
// constants, register map and types of the three-wire serial port
package serial_port_pkg;

  localparam int unsigned MAIN_CLK_HZ = 10_000_000;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  // register byte addresses
  localparam logic [15:0] ADDR_MODE = 16'hffb0;
  localparam logic [15:0] ADDR_CLKSEL = 16'hffb1;
  localparam logic [15:0] ADDR_TXBUF = 16'hffb2;
  localparam logic [15:0] ADDR_SHIFT = 16'hffb3;

  // mode register fields
  localparam int unsigned MODE_EN_BIT = 7;
  localparam int unsigned MODE_TRMD_BIT = 6;
  localparam int unsigned MODE_DIR_BIT = 4;
  localparam int unsigned MODE_ACTIVE_BIT = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // clock select register fields
  localparam int unsigned CLK_CKP_BIT = 4;
  localparam int unsigned CLK_DAP_BIT = 3;
  localparam int unsigned CLK_CKS_LSB = 0;
  localparam int unsigned CKS_W = 3;
  localparam logic [7:0] CLKSEL_RESET = 8'h10;
  localparam logic [2:0] CKS_EXTERNAL = 3'h7;

  // internal serial clock period is 2^(code+2) main clocks,
  // so one half period is 2^(code+1)
  localparam int unsigned DIV_HALF_SHIFT = 1;
  localparam int unsigned PRESCALE_W = 8;

  // one byte is sixteen half periods
  localparam int unsigned BITS_PER_XFER = 8;
  localparam int unsigned HALF_W = 4;
  localparam logic [3:0] HALF_LAST = 4'hf;
  localparam logic [3:0] HALF_ZERO = 4'h0;
  localparam logic [3:0] HALF_ONE = 4'h1;

  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } xfer_state_t;

endpackage

// ---- core/serial_prescale_if.sv ----
// link between transfer engine and serial clock prescaler
interface serial_prescale_if;
  logic run;
  logic [2:0] sel;
  logic tick;

  modport engine (
    output run,
    output sel,
    input tick
  );

  modport gen (
    input run,
    input sel,
    output tick
  );
endinterface

// ---- core/serial_prescaler.sv ----
// half-period tick generator for the internal serial clock
module serial_prescaler #(
  parameter int unsigned CNT_W = serial_port_pkg::PRESCALE_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  serial_prescale_if.gen pre
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } pre_state_t;

  pre_state_t q_reg;
  pre_state_t q_next;
  logic [CNT_W-1:0] half_m1;

  always_comb begin
    half_m1 = CNT_W'((32'h1 << (32'(pre.sel) +
      serial_port_pkg::DIV_HALF_SHIFT)) - 32'h1);
    q_next = q_reg;
    q_next.tick = 1'b0;
    if (!pre.run) begin
      // restart from zero so each byte begins with a full half period
      q_next.cnt = '0;
    end else if (q_reg.cnt == half_m1) begin
      q_next.cnt = '0;
      q_next.tick = 1'b1;
    end else begin
      q_next.cnt = q_reg.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign pre.tick = q_reg.tick;

endmodule

// ---- core/three_wire_serial_port.sv ----
// three-wire clocked serial port with register access
// Overview of operation
// RULE1 - enable bit 0 stops all activity and releases the three pins
// RULE2 - transmit/receive mode: writing the transmit buffer starts an 8-bit exchange
// RULE3 - receive-only mode: reading the shift register starts an 8-bit reception
// RULE4 - receive-only mode holds the serial output pin low
// RULE5 - first-bit select: 0 sends and receives MSB first, 1 LSB first
// RULE6 - read-only active flag in mode bit 0, 1 while a transfer runs
// RULE7 - clearing the enable bit clears the active flag, aborting the transfer
// RULE8 - polarity and phase bits pick one of four clock/data types
// RULE9 - clock code 0..6 divides main clock by 4..256, 7 is external
// RULE10 - reset loads mode register 00h and clock select 10h, type 3
// RULE11 - transmit buffer and shift register need no reset value
// RULE12 - shift register serialises the buffer out and collects input bits
// RULE13 - transmit buffer reads and writes; shift register reads
// RULE14 - software leaves both data registers alone while active
// RULE15 - software keeps mode and bit order fixed while active
// RULE16 - software writes clock select only while enabled
// RULE17 - software always writes 0 to mode bit 5
// RULE18 - active flag rises once a transfer has started
// RULE19 - after eight bits: completion pulse, active flag drops
// RULE20 - internal clock drives eight pulses, external clock edges are followed
// RULE21 - clock select holds polarity bit 4, phase bit 3, code bits 2..0
//
// Added by the designer: the strobed register port.
module three_wire_serial_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic sck_in_i,
  output logic sck_out_o,
  output logic sck_oe_o,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  output logic completion_interrupt_o,
  output logic transfer_active_o
);

  typedef struct packed {
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic si_s1;
    logic si_s2;
    logic operation_enable;
    logic transmit_receive_select;
    logic first_bit_select;
    logic clock_polarity;
    logic data_phase;
    logic [2:0] clock_select;
    logic [7:0] transmit_buffer;
    logic [7:0] shift_reg;
    serial_port_pkg::xfer_state_t state;
    logic [3:0] half_cnt;
    logic rx_bit;
    logic sck_lvl;
    logic so_bit;
    logic sck_oe;
    logic so_oe;
    logic done;
    logic [7:0] rdata;
  } port_state_t;

  localparam port_state_t STATE_RESET = '{
    sck_s1: 1'b0,
    sck_s2: 1'b0,
    sck_s3: 1'b0,
    si_s1: 1'b0,
    si_s2: 1'b0,
    operation_enable: serial_port_pkg::MODE_RESET[
      serial_port_pkg::MODE_EN_BIT],
    transmit_receive_select: serial_port_pkg::MODE_RESET[
      serial_port_pkg::MODE_TRMD_BIT],
    first_bit_select: serial_port_pkg::MODE_RESET[
      serial_port_pkg::MODE_DIR_BIT],
    clock_polarity: serial_port_pkg::CLKSEL_RESET[
      serial_port_pkg::CLK_CKP_BIT],
    data_phase: serial_port_pkg::CLKSEL_RESET[
      serial_port_pkg::CLK_DAP_BIT],
    clock_select: serial_port_pkg::CLKSEL_RESET[
      serial_port_pkg::CLK_CKS_LSB +: serial_port_pkg::CKS_W],
    transmit_buffer: serial_port_pkg::BYTE_ZERO,
    shift_reg: serial_port_pkg::BYTE_ZERO,
    state: serial_port_pkg::ST_IDLE,
    half_cnt: serial_port_pkg::HALF_ZERO,
    rx_bit: 1'b0,
    // idle clock level is the inverse of the polarity bit
    sck_lvl: ~serial_port_pkg::CLKSEL_RESET[
      serial_port_pkg::CLK_CKP_BIT],
    so_bit: 1'b0,
    sck_oe: 1'b0,
    so_oe: 1'b0,
    done: 1'b0,
    rdata: serial_port_pkg::BYTE_ZERO
  };

  port_state_t q_reg;
  port_state_t q_next;

  serial_prescale_if pre ();

  serial_prescaler #(
    .CNT_W(serial_port_pkg::PRESCALE_W)
  ) u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pre(pre)
  );

  // bit leaving the shift register first, per bit order
  function automatic logic out_bit(input logic [7:0] sr, input logic lsb);
    out_bit = lsb ? sr[0] : sr[7];
  endfunction

  // shift one received bit in at the far end
  function automatic logic [7:0] shift_in(input logic [7:0] sr,
                                          input logic lsb,
                                          input logic b);
    shift_in = lsb ? {b, sr[7:1]} : {sr[6:0], b};
  endfunction

  logic idle_lvl;
  logic ext_clk;
  logic busy;
  logic edge_evt;
  logic edge_lead;
  logic ext_lead;
  logic ext_trail;
  logic start_tx;
  logic start_rx;
  logic [7:0] mode_rd;
  logic [7:0] clksel_rd;

  always_comb begin
    idle_lvl = ~q_reg.clock_polarity; // RULE8
    ext_clk = q_reg.clock_select == serial_port_pkg::CKS_EXTERNAL; // RULE9
    busy = q_reg.state == serial_port_pkg::ST_SHIFT;
    // only the second and third sync stages are compared
    ext_lead = (q_reg.sck_s3 == idle_lvl) && (q_reg.sck_s2 != idle_lvl);
    ext_trail = (q_reg.sck_s3 != idle_lvl) && (q_reg.sck_s2 == idle_lvl);
    // leading and trailing edges must alternate; strays are ignored
    if (ext_clk) begin
      edge_evt = q_reg.half_cnt[0] ? ext_trail : ext_lead; // RULE20
    end else begin
      edge_evt = pre.tick; // RULE20
    end
    edge_lead = ~q_reg.half_cnt[0];

    start_tx = wr_i && (addr_i == serial_port_pkg::ADDR_TXBUF) &&
      q_reg.operation_enable && q_reg.transmit_receive_select &&
      !busy; // RULE2
    start_rx = rd_i && (addr_i == serial_port_pkg::ADDR_SHIFT) &&
      q_reg.operation_enable && !q_reg.transmit_receive_select &&
      !busy; // RULE3

    mode_rd = serial_port_pkg::BYTE_ZERO;
    mode_rd[serial_port_pkg::MODE_EN_BIT] = q_reg.operation_enable;
    mode_rd[serial_port_pkg::MODE_TRMD_BIT] =
      q_reg.transmit_receive_select;
    mode_rd[serial_port_pkg::MODE_DIR_BIT] = q_reg.first_bit_select;
    mode_rd[serial_port_pkg::MODE_ACTIVE_BIT] = busy; // RULE6

    clksel_rd = serial_port_pkg::BYTE_ZERO;
    clksel_rd[serial_port_pkg::CLK_CKP_BIT] = q_reg.clock_polarity;
    clksel_rd[serial_port_pkg::CLK_DAP_BIT] = q_reg.data_phase;
    clksel_rd[serial_port_pkg::CLK_CKS_LSB +: serial_port_pkg::CKS_W] =
      q_reg.clock_select; // RULE21
  end

  always_comb begin
    q_next = q_reg;
    q_next.done = 1'b0;
    q_next.sck_s1 = sck_in_i;
    q_next.sck_s2 = q_reg.sck_s1;
    q_next.sck_s3 = q_reg.sck_s2;
    q_next.si_s1 = si_i;
    q_next.si_s2 = q_reg.si_s1;

    // read data stand for the one cycle after the strobe only
    q_next.rdata = serial_port_pkg::BYTE_ZERO;
    if (rd_i) begin
      unique case (addr_i)
        serial_port_pkg::ADDR_MODE: q_next.rdata = mode_rd;
        serial_port_pkg::ADDR_CLKSEL: q_next.rdata = clksel_rd;
        serial_port_pkg::ADDR_TXBUF: begin
          q_next.rdata = q_reg.transmit_buffer; // RULE13
        end
        serial_port_pkg::ADDR_SHIFT: begin
          q_next.rdata = q_reg.shift_reg; // RULE13
        end
        default: q_next.rdata = serial_port_pkg::BYTE_ZERO;
      endcase
    end

    // transfer engine
    if (busy && edge_evt) begin
      q_next.half_cnt = q_reg.half_cnt + serial_port_pkg::HALF_ONE;
      if (edge_lead) begin
        q_next.sck_lvl = ~idle_lvl;
        if (q_reg.data_phase) begin
          q_next.rx_bit = q_reg.si_s2;
        end else begin
          q_next.so_bit = out_bit(q_reg.shift_reg,
            q_reg.first_bit_select); // RULE12 RULE5
        end
      end else begin
        q_next.sck_lvl = idle_lvl;
        if (q_reg.data_phase) begin
          q_next.shift_reg = shift_in(q_reg.shift_reg,
            q_reg.first_bit_select, q_reg.rx_bit); // RULE12 RULE5
          q_next.so_bit = out_bit(q_next.shift_reg,
            q_reg.first_bit_select);
        end else begin
          q_next.shift_reg = shift_in(q_reg.shift_reg,
            q_reg.first_bit_select, q_reg.si_s2); // RULE12 RULE5
        end
        if (q_reg.half_cnt == serial_port_pkg::HALF_LAST) begin
          q_next.state = serial_port_pkg::ST_IDLE; // RULE19
          q_next.done = 1'b1; // RULE19
          q_next.half_cnt = serial_port_pkg::HALF_ZERO;
        end
      end
    end

    // starts; software leaves the data registers alone during a transfer by contract
    if (start_tx || start_rx) begin
      q_next.state = serial_port_pkg::ST_SHIFT; // RULE18
      q_next.half_cnt = serial_port_pkg::HALF_ZERO;
      q_next.sck_lvl = idle_lvl;
      if (start_tx) begin
        q_next.shift_reg = wdata_i; // RULE12
        // phase type with early data shows the first bit at once
        q_next.so_bit = q_reg.data_phase ?
          out_bit(wdata_i, q_reg.first_bit_select) : q_reg.so_bit;
      end
    end

    if (wr_i) begin
      unique case (addr_i)
        serial_port_pkg::ADDR_MODE: begin
          q_next.operation_enable = wdata_i[serial_port_pkg::MODE_EN_BIT];
          q_next.transmit_receive_select =
            wdata_i[serial_port_pkg::MODE_TRMD_BIT];
          q_next.first_bit_select = wdata_i[serial_port_pkg::MODE_DIR_BIT];
          // bit 0 ignores writes; bit 5 is held at zero
          if (!wdata_i[serial_port_pkg::MODE_EN_BIT]) begin
            q_next.state = serial_port_pkg::ST_IDLE; // RULE7
            q_next.half_cnt = serial_port_pkg::HALF_ZERO; // RULE7
            q_next.done = 1'b0;
          end
        end
        serial_port_pkg::ADDR_CLKSEL: begin
          q_next.clock_polarity = wdata_i[serial_port_pkg::CLK_CKP_BIT];
          q_next.data_phase = wdata_i[serial_port_pkg::CLK_DAP_BIT];
          q_next.clock_select = wdata_i[
            serial_port_pkg::CLK_CKS_LSB +: serial_port_pkg::CKS_W];
        end
        serial_port_pkg::ADDR_TXBUF: begin
          q_next.transmit_buffer = wdata_i; // RULE13
        end
        default: begin
        end
      endcase
    end

    // idle clock follows the selected polarity while not shifting
    if (q_next.state == serial_port_pkg::ST_IDLE) begin
      q_next.sck_lvl = ~q_next.clock_polarity; // RULE8
    end

    // pin ownership follows the latest settings
    q_next.sck_oe = q_next.operation_enable &&
      (q_next.clock_select != serial_port_pkg::CKS_EXTERNAL); // RULE1 RULE9
    q_next.so_oe = q_next.operation_enable; // RULE1
    if (!q_next.transmit_receive_select || !q_next.operation_enable) begin
      q_next.so_bit = 1'b0; // RULE4 RULE1
    end
  end

  assign pre.run = busy && !ext_clk; // RULE20
  assign pre.sel = q_reg.clock_select; // RULE9

  // data registers are cleared for determinism; software may not rely on it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_reg <= STATE_RESET; // RULE10 RULE11
    end else begin
      q_reg <= q_next;
    end
  end

  assign rdata_o = q_reg.rdata;
  assign sck_out_o = q_reg.sck_lvl;
  assign sck_oe_o = q_reg.sck_oe;
  assign so_o = q_reg.so_bit;
  assign so_oe_o = q_reg.so_oe;
  assign completion_interrupt_o = q_reg.done;
  assign transfer_active_o = q_reg.state == serial_port_pkg::ST_SHIFT;

endmodule

// ---- tb/serial_port_properties.sv ----
// concurrent checks of the serial port seen from its pins
module serial_port_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic sck_out_o,
  input wire logic sck_oe_o,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic completion_interrupt_o,
  input wire logic transfer_active_o
);
  logic [7:0] mode_reg, cs_reg, cnt_reg, gap_reg, half;
  logic sck_reg, tog, ext, en, trx, wm, wt, rm, rc, rs;
  assign wm = wr_i && addr_i == serial_port_pkg::ADDR_MODE;
  assign wt = wr_i && addr_i == serial_port_pkg::ADDR_TXBUF;
  assign rm = rd_i && addr_i == serial_port_pkg::ADDR_MODE;
  assign rc = rd_i && addr_i == serial_port_pkg::ADDR_CLKSEL;
  assign rs = rd_i && addr_i == serial_port_pkg::ADDR_SHIFT;
  assign en = mode_reg[7];
  assign trx = mode_reg[6];
  assign ext = cs_reg[2:0] == 3'h7;
  assign tog = sck_out_o != sck_reg;
  assign half = 8'h01 << (cs_reg[2:0] + 3'h1);
  // shadows keep only writable bits; mode reads add the active flag
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_reg <= 8'h00;
      cs_reg <= 8'h10;
      cnt_reg <= 8'h00;
      gap_reg <= 8'h00;
      sck_reg <= 1'b0;
    end else begin
      if (wm) begin
        mode_reg <= wdata_i & 8'hd0;
      end
      if (wr_i && addr_i == serial_port_pkg::ADDR_CLKSEL) begin
        cs_reg <= wdata_i & 8'h1f;
      end
      cnt_reg <= $rose(transfer_active_o) ? 8'h00 : cnt_reg + 8'(tog);
      gap_reg <= tog ? 8'h01 : gap_reg + 8'h01;
      sck_reg <= sck_out_o;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  stop_releases_a: assert property (!en && !$past(en) |->
    !sck_oe_o && !so_oe_o && !transfer_active_o)
    else $error("pins driven while disabled");
  abort_now_a: assert property (wm && !wdata_i[7] |=>
    !transfer_active_o && !completion_interrupt_o)
    else $error("transfer not aborted");
  tx_start_a: assert property (wt && en && trx && !transfer_active_o
    |=> transfer_active_o) else $error("write did not start");
  rx_start_a: assert property (rs && en && !trx && !transfer_active_o
    |=> transfer_active_o) else $error("read did not start");
  rx_low_a: assert property (!trx && !$past(trx) |-> !so_o)
    else $error("output not low in receive mode");
  done_drop_a: assert property (completion_interrupt_o |->
    $past(transfer_active_o) && !transfer_active_o)
    else $error("done pulse without active drop");
  edge_count_a: assert property (completion_interrupt_o && !ext
    |=> cnt_reg == 8'h10) else $error("wrong clock edge count");
  half_period_a: assert property (transfer_active_o && tog && !ext
    && cnt_reg != 8'h00 |-> gap_reg == half)
    else $error("wrong serial clock half period");
  mode_read_a: assert property (rm |=> rdata_o ==
    ($past(mode_reg) | {7'h00, $past(transfer_active_o)}))
    else $error("mode read mismatch");
  clk_read_a: assert property (rc |=> rdata_o == $past(cs_reg))
    else $error("clock select read mismatch");
endmodule
bind three_wire_serial_port serial_port_properties serial_port_properties_i (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sck_out_o(sck_out_o),
  .sck_oe_o(sck_oe_o), .so_o(so_o), .so_oe_o(so_oe_o),
  .completion_interrupt_o(completion_interrupt_o),
  .transfer_active_o(transfer_active_o)
);

// ---- tb/periph_model.sv ----
// clocked serial peripheral on the far side of the port
module periph_model (
  input wire logic sck_i,
  input wire logic so_i,
  input wire logic ckp_i,
  input wire logic dap_i,
  input wire logic lsb_i,
  input wire logic load_i,
  input wire logic [7:0] tx_i,
  output logic si_o,
  output logic [7:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int n;
  function automatic logic pick(input int k);
    return lsb_i ? tx_i[k] : tx_i[7 - k];
  endfunction
  initial begin
    si_o = 1'b0;
    rx_o = 8'h00;
    n = 8;
  end
  always @(posedge load_i) begin
    n = 0;
    si_o = dap_i ? pick(0) : ~si_o;
  end
  // outside a frame the line toggles so stale bits never look valid
  always @(sck_i) begin
    if ((sck_i == ckp_i) ^ dap_i) begin
      si_o = n < 8 ? pick(n) : ~si_o;
    end else if (n < 8) begin
      rx_o[lsb_i ? n : 7 - n] = so_i;
      n++;
    end
  end
endmodule

// ---- tb/three_wire_serial_port_tb.sv ----
// self-checking bench for the three-wire serial port
module three_wire_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, wr_s, rd_s, sck_in, sck_out, sck_oe, si, so, so_oe;
  logic done, act, ckp, dap, lsb, ld, ok;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, d, tx, ptx, prx;
  logic [2:0] code;
  int n_errors, comparisons, i;
  wire sck = sck_oe ? sck_out : sck_in;
  three_wire_serial_port three_wire_serial_port_i (
    .clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .sck_in_i(sck_in),
    .sck_out_o(sck_out), .sck_oe_o(sck_oe), .si_i(si), .so_o(so),
    .so_oe_o(so_oe), .completion_interrupt_o(done),
    .transfer_active_o(act));
  periph_model periph_model_i (.sck_i(sck), .so_i(so), .ckp_i(ckp),
    .dap_i(dap), .lsb_i(lsb), .load_i(ld), .tx_i(ptx), .si_o(si),
    .rx_o(prx));
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic bus_rd(input logic [15:0] a, output logic [7:0] v);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, s);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_done(output logic seen);
    seen = 1'b0;
    for (int k = 0; k < 5000 && !seen; k++) begin
      @(posedge clk);
      seen = done === 1'b1;
    end
  endtask
  task automatic load_peer(input logic [7:0] v);
    @(posedge clk);
    ptx = v;
    ld = 1'b1;
    #1 ld = 1'b0;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // longest byte is 2048 clocks; all tests need well under 10000
  initial begin
    #2_000_000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    {rst, wr_s, rd_s, sck_in, ld, ckp, dap, lsb} = 8'h80;
    {addr, wdata, ptx} = 32'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus_rd(serial_port_pkg::ADDR_MODE, d);
    chk("mode reset", 8'h00, d);
    bus_rd(serial_port_pkg::ADDR_CLKSEL, d);
    chk("clksel reset", 8'h10, d);
    bus_rd(16'hffb4, d);
    chk("unmapped", 8'h00, d);
    bus_wr(serial_port_pkg::ADDR_MODE, 8'h01);
    bus_rd(serial_port_pkg::ADDR_MODE, d);
    chk("flag ro", 8'h00, d);
    for (i = 0; i < 8; i++) begin
      {lsb, ckp, dap} = 3'(i);
      code = 3'(i % 7);
      tx = 8'h3c + 8'(i * 37);
      bus_wr(serial_port_pkg::ADDR_MODE, {3'h6, lsb, 4'h0});
      bus_wr(serial_port_pkg::ADDR_CLKSEL, {3'h0, ckp, dap, code});
      load_peer(~tx);
      bus_wr(serial_port_pkg::ADDR_TXBUF, tx);
      wait_done(ok);
      chk("done", 8'h01, {7'h00, ok});
      bus_rd(serial_port_pkg::ADDR_MODE, d);
      chk("mode", {3'h6, lsb, 4'h0}, d);
      chk("peer rx", tx, prx);
      bus_rd(serial_port_pkg::ADDR_TXBUF, d);
      chk("txbuf", tx, d);
      bus_rd(serial_port_pkg::ADDR_SHIFT, d);
      // two-stage input sync cannot follow the two fastest clocks
      if (code > 3'h1) chk("shift", ~tx, d);
    end
    {lsb, ckp, dap} = 3'h2;
    bus_wr(serial_port_pkg::ADDR_MODE, 8'h80);
    bus_wr(serial_port_pkg::ADDR_CLKSEL, 8'h13);
    load_peer(8'ha5);
    bus_rd(serial_port_pkg::ADDR_SHIFT, d);
    wait_done(ok);
    chk("rx done", 8'h01, {7'h00, ok});
    bus_rd(serial_port_pkg::ADDR_SHIFT, d);
    chk("rx byte", 8'ha5, d);
    chk("so low", 8'h00, prx);
    // start a reception and cut it off during its first bit
    bus_rd(serial_port_pkg::ADDR_SHIFT, d);
    bus_rd(serial_port_pkg::ADDR_MODE, d);
    chk("busy", 8'h81, d);
    repeat (20) @(posedge clk);
    bus_wr(serial_port_pkg::ADDR_MODE, 8'h00);
    bus_rd(serial_port_pkg::ADDR_MODE, d);
    chk("abort", 8'h00, d);
    chk("pins", 8'h00, {6'h00, sck_oe, so_oe});
    bus_wr(serial_port_pkg::ADDR_TXBUF, 8'h11);
    bus_rd(serial_port_pkg::ADDR_MODE, d);
    chk("no start", 8'h00, d);
    bus_wr(serial_port_pkg::ADDR_MODE, 8'hc0);
    bus_wr(serial_port_pkg::ADDR_CLKSEL, 8'h17);
    load_peer(8'h96);
    bus_wr(serial_port_pkg::ADDR_TXBUF, 8'h69);
    chk("sck drive", 8'h00, {7'h00, sck_oe});
    repeat (16) begin
      repeat (10) @(posedge clk);
      sck_in <= ~sck_in;
    end
    wait_done(ok);
    chk("ext done", 8'h01, {7'h00, ok});
    chk("ext peer", 8'h69, prx);
    bus_rd(serial_port_pkg::ADDR_SHIFT, d);
    chk("ext shift", 8'h96, d);
    report_and_stop;
  end
endmodule
